// file: mac_channel_pointers_and_statistics_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mac_channel_pointers_and_statistics_tb;
    import mcps_pkg::*;
    // bus, dma and frame side stimulus and results
    logic                   aclk, aresetn, awvalid, wvalid, bready;
    logic                   arvalid, rready, awready, wready, bvalid;
    logic                   arready, rvalid, rx_active, frame_end;
    logic                   receive_error_input, code_discard, pend;
    logic [7:0]             awaddr, araddr;
    logic [31:0]            wdata, rdata, rd, eg, eb, em;
    logic [3:0]             wstrb;
    logic [1:0]             bresp, rresp, rs;
    logic [NCHAN-1:0]       rx_hdp_clear, tx_done, rx_done, rx_dma_enable;
    logic [NCHAN-1:0]       tx_chan_int, rx_chan_int;
    logic [NCHAN-1:0][31:0] tx_progress, rx_progress;
    mcps_frame_t            frame;
    int                     fails, n_tests;
    // frame report, then good/bcast/mcast increments
    logic [25:0]            rows [9];
    localparam logic [22:0] UNI = {16'h0100, 7'b0111000};

    mcps_regs i_mcps_regs (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .rx_hdp_clear(rx_hdp_clear), .tx_done(tx_done), .rx_done(rx_done),
        .tx_progress(tx_progress), .rx_progress(rx_progress),
        .rx_dma_enable(rx_dma_enable), .tx_chan_int(tx_chan_int),
        .rx_chan_int(rx_chan_int), .rx_active(rx_active),
        .receive_error_input(receive_error_input), .frame_end(frame_end),
        .frame(frame), .code_discard(code_discard),
        .statistics_interrupt_pending(pend)
    );

    task automatic finish_test;
        if (fails == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, g, x);
        end
    endtask

    // write: both halves offered, each dropped once taken
    task automatic wrw(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int   t;
        logic pa, pw, ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        tb = 1'b0;
        t = 0;
        while (!tb && t < 50) begin
            @(negedge aclk);
            ta = pa && awready;
            tw = pw && wready;
            tb = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (ta) begin
                awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (tw) begin
                wvalid <= 1'b0;
                pw = 1'b0;
            end
            if (tb) bready <= 1'b0;
            t++;
        end
        if (!tb) fails++;
    endtask

    task automatic rdw(input logic [7:0] a);
        int   t;
        logic pa, ta, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        pa = 1'b1;
        tr = 1'b0;
        t = 0;
        while (!tr && t < 50) begin
            @(negedge aclk);
            ta = pa && arready;
            tr = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ta) begin
                arvalid <= 1'b0;
                pa = 1'b0;
            end
            if (tr) rready <= 1'b0;
            t++;
        end
        if (!tr) fails++;
    endtask

    // one frame report, receive error held through the frame
    task automatic sendf(input logic [22:0] f, input logic e);
        @(posedge aclk);
        frame <= mcps_frame_t'(f);
        frame_end <= 1'b1;
        rx_active <= 1'b1;
        receive_error_input <= e;
        @(posedge aclk);
        frame_end <= 1'b0;
        rx_active <= 1'b0;
        receive_error_input <= 1'b0;
        @(negedge aclk);
        chk({31'h0, code_discard}, {31'h0, e});
    endtask

    task automatic chk3;
        rdw(8'ha0);
        chk(rd, eg);
        rdw(8'ha4);
        chk(rd, eb);
        rdw(8'ha8);
        chk(rd, em);
    endtask

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #3000000;
        fails++;
        finish_test;
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {rx_active, frame_end, receive_error_input} = 3'h0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {rx_hdp_clear, tx_done, rx_done} = '0;
        tx_progress = '0;
        rx_progress = '0;
        tx_progress[2] = 32'h0000_1230;
        rx_progress[5] = 32'h0000_4560;
        frame = '0;
        rows = '{{16'h0040, 7'b0111110, 3'b110}, {16'h05ee, 7'b0111010, 3'b101},
                 {16'h003f, 7'b0111000, 3'b000}, {16'h05ef, 7'b0111000, 3'b000},
                 {16'h0100, 7'b0011000, 3'b000}, {16'h0100, 7'b1101000, 3'b000},
                 {16'h0100, 7'b0110000, 3'b000}, {16'h0100, 7'b0111101, 3'b000},
                 {16'h0100, 7'b0111000, 3'b100}};
        {eg, eb, em} = '0;
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // a count taken before the delayed clear is wiped
        sendf(UNI, 1'b0);
        repeat (34) @(posedge aclk);
        rdw(8'ha0);
        chk(rd, 32'h1);
        chk3;
        rdw(8'h88);
        chk({31'h0, rd[STS_READY_BIT]}, 32'h1);
        for (int i = 0; i < 9; i++) begin
            sendf(rows[i][25:3], 1'b0);
            eg += rows[i][2];
            eb += rows[i][1];
            em += rows[i][0];
            chk3;
        end
        sendf(UNI, 1'b1);
        chk3;
        wrw(8'h84, 32'h0000_0080, STRB_FULL);
        sendf({16'h0081, 7'b0111000}, 1'b0);
        sendf({16'h0080, 7'b0111000}, 1'b0);
        eg += 1;
        chk3;
        // direct store, threshold, decrement, clamp and wrap
        wrw(8'h80, 32'h0000_0002, STRB_FULL);
        wrw(8'ha0, 32'h8000_0000, STRB_FULL);
        chk({31'h0, pend}, 32'h1);
        wrw(8'h80, 32'h0000_0003, STRB_FULL);
        wrw(8'ha0, 32'h0000_0001, STRB_FULL);
        chk({31'h0, pend}, 32'h0);
        rdw(8'ha0);
        chk(rd, 32'h7fff_ffff);
        wrw(8'ha0, 32'hffff_ffff, STRB_FULL);
        rdw(8'ha0);
        chk(rd, 32'h0);
        wrw(8'h80, 32'h0000_0002, STRB_FULL);
        wrw(8'ha0, 32'hffff_ffff, STRB_FULL);
        sendf({16'h0080, 7'b0111000}, 1'b0);
        rdw(8'ha0);
        chk(rd, 32'h0);
        wrw(8'ha4, 32'h0000_0005, 4'h3);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        rdw(8'ha4);
        chk(rd, eb);
        rdw(8'hfc);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        // host zeroes every head pointer before using channels
        for (int i = 0; i < NCHAN; i++)
            wrw(8'(4 * i), WORD_ZERO, STRB_FULL);
        // head pointer: enable, refused rewrite, dma clear
        wrw(8'h0c, 32'h0000_0100, STRB_FULL);
        chk({31'h0, rx_dma_enable[3]}, 32'h1);
        wrw(8'h0c, 32'h0000_0200, STRB_FULL);
        rdw(8'h0c);
        chk(rd, 32'h0000_0100);
        rdw(8'h88);
        chk({31'h0, rd[STS_HDPERR_BIT]}, 32'h1);
        @(posedge aclk);
        rx_hdp_clear <= 8'h08;
        @(posedge aclk);
        rx_hdp_clear <= 8'h00;
        @(negedge aclk);
        chk({31'h0, rx_dma_enable[3]}, 32'h0);
        // completion pointers drop the interrupt only on a match
        @(posedge aclk);
        tx_done <= 8'h04;
        rx_done <= 8'h20;
        @(posedge aclk);
        tx_done <= 8'h00;
        rx_done <= 8'h00;
        wrw(8'h48, 32'h0000_0999, STRB_FULL);
        wrw(8'h74, 32'h0000_0999, STRB_FULL);
        chk({30'h0, tx_chan_int[2], rx_chan_int[5]}, 32'h3);
        wrw(8'h48, 32'h0000_1230, STRB_FULL);
        wrw(8'h74, 32'h0000_4560, STRB_FULL);
        @(negedge aclk);
        chk({30'h0, tx_chan_int[2], rx_chan_int[5]}, 32'h0);
        finish_test;
    end
endmodule // mac_channel_pointers_and_statistics_tb
`default_nettype wire

// file: mcps_pkg.sv
`default_nettype none
package mcps_pkg;

    // channel and statistics counts
    localparam int NCHAN = 8;
    localparam int NSTAT = 3;

    // address decode: byte address [7:5] picks a group, [4:2] the entry
    localparam logic [2:0] GRP_HDP  = 3'h0;
    localparam logic [2:0] GRP_TXCP = 3'h2;
    localparam logic [2:0] GRP_RXCP = 3'h3;
    localparam logic [2:0] GRP_MISC = 3'h4;
    localparam logic [2:0] GRP_STAT = 3'h5;
    localparam logic [2:0] IDX_CTRL   = 3'h0; // 0x80
    localparam logic [2:0] IDX_MAXLEN = 3'h1; // 0x84
    localparam logic [2:0] IDX_STATUS = 3'h2; // 0x88
    localparam logic [2:0] STAT_GOOD  = 3'h0; // 0xa0
    localparam logic [2:0] STAT_BCAST = 3'h1; // 0xa4
    localparam logic [2:0] STAT_MCAST = 3'h2; // 0xa8

    // field positions
    localparam int CTRL_GIG_BIT    = 0;
    localparam int CTRL_STATIE_BIT = 1;
    localparam int STS_PEND_BIT    = 0;
    localparam int STS_HDPERR_BIT  = 1;
    localparam int STS_READY_BIT   = 2;
    localparam int STAT_TOP_BIT    = 31;

    // reset values and limits
    localparam logic [15:0] MAXLEN_RST = 16'h05ee;
    localparam logic [15:0] MIN_FRAME  = 16'h0040;
    localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
    localparam logic [3:0]  STRB_FULL  = 4'hf;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // statistics clear delay after reset release, in clocks
    localparam logic [5:0] STAT_CLR_CNT  = 6'h26;
    localparam logic [5:0] STAT_CLR_LAST = STAT_CLR_CNT - 6'h01;

    // report of one finished receive frame
    typedef struct packed {
        logic [15:0] byte_count;
        logic        odd_nibbles;
        logic        fcs_ok;
        logic        fcs_ok_trunc;
        logic        addr_match;
        logic        dest_bcast;
        logic        dest_mcast;
        logic        overrun;
    } mcps_frame_t;

    // command to one statistics counter
    typedef struct packed {
        logic        clear;
        logic        inc;
        logic        wr;
        logic        dec_mode;
        logic [31:0] wdata;
    } mcps_stat_cmd_t;

    // statistics clear sequencer
    typedef enum logic [1:0] {
        CLR_WAIT = 2'b01,
        CLR_RUN  = 2'b10
    } mcps_clr_st_t;

endpackage
`default_nettype wire

// file: mcps_regs.sv
// Notes on behaviour
// R1: nonzero rx head pointer enables channel DMA
// R2: host never rewrites nonzero head pointer
// R3: host zeroes head pointers after reset
// R4: host writes last processed descriptor address
// R5: completion write matching progress drops interrupt
// R6: counters cleared 38 clocks after reset
// R7: gigabit mode: write subtracts from counter
// R8: oversized decrement leaves counter at zero
// R9: gigabit mode clear: write stores directly
// R10: host uses full 32-bit counter writes
// R11: enabled interrupt when counter top bit set
// R12: decrement below threshold removes interrupt
// R13: counters wrap from all ones to zero
// R14: counters 32 bits, memory mapped
// R15: good frames: matched, sized, error free
// R16: broadcast: good frames to all-ones address
// R17: multicast: good non-broadcast multicast frames
// R18: overruns leave frame counters unchanged
// R19: even nibbles plus bad check: crc
// R20: odd nibbles, bad truncated check: alignment
// R21: receive error during frame: code error
// R22: upper length from programmable maximum length
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module mcps_regs (
    // clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // axi4-lite write address and data
    input  wire logic [7:0]                    awaddr,
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    input  wire logic                          wvalid,
    output logic                               wready,
    // axi4-lite write response
    output logic [1:0]                         bresp,
    output logic                               bvalid,
    input  wire logic                          bready,
    // axi4-lite read
    input  wire logic [7:0]                    araddr,
    input  wire logic                          arvalid,
    output logic                               arready,
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp,
    output logic                               rvalid,
    input  wire logic                          rready,
    // dma engine side, one bit or word per channel
    input  wire logic [mcps_pkg::NCHAN-1:0]    rx_hdp_clear,
    input  wire logic [mcps_pkg::NCHAN-1:0]    tx_done,
    input  wire logic [mcps_pkg::NCHAN-1:0]    rx_done,
    input  wire logic [mcps_pkg::NCHAN-1:0][31:0] tx_progress,
    input  wire logic [mcps_pkg::NCHAN-1:0][31:0] rx_progress,
    output logic [mcps_pkg::NCHAN-1:0]         rx_dma_enable,
    output logic [mcps_pkg::NCHAN-1:0]         tx_chan_int,
    output logic [mcps_pkg::NCHAN-1:0]         rx_chan_int,
    // receive frame reports
    input  wire logic                          rx_active,
    input  wire logic                          receive_error_input,
    input  wire logic                          frame_end,
    input  wire mcps_pkg::mcps_frame_t         frame,
    output logic                               code_discard,
    // statistics interrupt
    output logic                               statistics_interrupt_pending
);
    import mcps_pkg::*;

    // write and read channel holding registers
    logic        aw_full_q;
    logic [7:0]  waddr_q;
    logic        w_full_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    // register state
    logic [31:0] hdp_q  [NCHAN];
    logic [31:0] txcp_q [NCHAN];
    logic [31:0] rxcp_q [NCHAN];
    logic [31:0] stat_q [NSTAT];
    logic        gig_q;
    logic        statie_q;
    logic [15:0] maxlen_q;
    logic        hdperr_q;
    logic        ready_q;
    logic [5:0]  clr_cnt_q;
    mcps_clr_st_t clr_st_q;
    logic        code_err_q;
    logic        code_discard_q;
    logic [NCHAN-1:0] txint_q;
    logic [NCHAN-1:0] rxint_q;

    // write decode
    wire       do_wr    = aw_full_q && w_full_q && !bvalid_q;
    wire [2:0] w_grp    = waddr_q[7:5];
    wire [2:0] w_idx    = waddr_q[4:2];
    wire       w_stat   = (w_grp == GRP_STAT) && (w_idx < 3'(NSTAT));
    wire       w_misc   = (w_grp == GRP_MISC) && (w_idx <= IDX_STATUS);
    wire       w_full32 = (wstrb_q == STRB_FULL);
    wire       w_map    = (w_grp == GRP_HDP) || (w_grp == GRP_TXCP) ||
                          (w_grp == GRP_RXCP) || w_misc || w_stat;
    // R10: partial counter writes refused
    wire       w_ok     = w_map && (!w_stat || w_full32);
    wire       wr_hdp   = do_wr && (w_grp == GRP_HDP);
    wire       wr_txcp  = do_wr && (w_grp == GRP_TXCP);
    wire       wr_rxcp  = do_wr && (w_grp == GRP_RXCP);
    wire       wr_ctrl  = do_wr && (w_grp == GRP_MISC) && (w_idx == IDX_CTRL);
    wire       wr_max   = do_wr && (w_grp == GRP_MISC) && (w_idx == IDX_MAXLEN);
    wire       wr_sts   = do_wr && (w_grp == GRP_MISC) && (w_idx == IDX_STATUS);
    wire       wr_stat  = do_wr && w_stat && w_full32;

    // handshakes: one write in flight, held until the response is taken
    assign awready = !aw_full_q && !bvalid_q;
    assign wready  = !w_full_q && !bvalid_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = !rvalid_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            waddr_q   <= 8'h00;
            wdata_q   <= WORD_ZERO;
            wstrb_q   <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_full_q <= 1'b1;
                waddr_q   <= awaddr;
            end
            if (wvalid && wready) begin
                w_full_q <= 1'b1;
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
            end
            if (do_wr) begin
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= w_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // read decode
    wire [2:0]  r_grp  = araddr[7:5];
    wire [2:0]  r_idx  = araddr[4:2];
    wire        r_stat = (r_grp == GRP_STAT) && (r_idx < 3'(NSTAT));
    wire        r_misc = (r_grp == GRP_MISC) && (r_idx <= IDX_STATUS);
    wire [31:0] r_ctrl = {30'h0, statie_q, gig_q};
    wire [31:0] r_sts  = {29'h0, ready_q, hdperr_q,
                          statistics_interrupt_pending};
    wire [31:0] r_misc_w = (r_idx == IDX_CTRL) ? r_ctrl :
                           (r_idx == IDX_MAXLEN) ? {16'h0, maxlen_q} : r_sts;
    wire        r_map  = (r_grp == GRP_HDP) || (r_grp == GRP_TXCP) ||
                         (r_grp == GRP_RXCP) || r_misc || r_stat;
    wire [31:0] r_word = (r_grp == GRP_HDP)  ? hdp_q[r_idx]  :
                         (r_grp == GRP_TXCP) ? txcp_q[r_idx] :
                         (r_grp == GRP_RXCP) ? rxcp_q[r_idx] :
                         r_misc ? r_misc_w :
                         r_stat ? stat_q[r_idx[1:0]] : WORD_ZERO;

    // read data registered at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= WORD_ZERO;
            rresp_q  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= r_word;
            rresp_q  <= r_map ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // R2: nonzero head pointer rewrite is an error
    wire hdp_bad = wr_hdp && (hdp_q[w_idx] != WORD_ZERO);

    // control, length limit and sticky error; set beats write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gig_q    <= 1'b0;
            statie_q <= 1'b0;
            maxlen_q <= MAXLEN_RST;
            hdperr_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                gig_q    <= wdata_q[CTRL_GIG_BIT];
                statie_q <= wdata_q[CTRL_STATIE_BIT];
            end
            // R22: programmable upper length
            if (wr_max) begin
                maxlen_q <= wdata_q[15:0];
            end
            if (hdp_bad) begin
                hdperr_q <= 1'b1;
            end else if (wr_sts && wdata_q[STS_HDPERR_BIT]) begin
                hdperr_q <= 1'b0;
            end
        end
    end

    // per-channel pointers and channel interrupts
    genvar ch;
    generate
        for (ch = 0; ch < NCHAN; ch++) begin : g_chan
            wire hdp_sel = wr_hdp && (w_idx == 3'(ch));
            wire tx_sel  = wr_txcp && (w_idx == 3'(ch));
            wire rx_sel  = wr_rxcp && (w_idx == 3'(ch));
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    hdp_q[ch]  <= WORD_ZERO;
                    txcp_q[ch] <= WORD_ZERO;
                    rxcp_q[ch] <= WORD_ZERO;
                    txint_q[ch] <= 1'b0;
                    rxint_q[ch] <= 1'b0;
                end else begin
                    // R1: load pointer only while idle
                    if (hdp_sel && !hdp_bad) begin
                        hdp_q[ch] <= wdata_q;
                    end else if (rx_hdp_clear[ch]) begin
                        hdp_q[ch] <= WORD_ZERO;
                    end
                    if (tx_sel) begin
                        txcp_q[ch] <= wdata_q;
                    end
                    if (rx_sel) begin
                        rxcp_q[ch] <= wdata_q;
                    end
                    // R5: matching acknowledge drops interrupt
                    if (tx_done[ch]) begin
                        txint_q[ch] <= 1'b1;
                    end else if (tx_sel && wdata_q == tx_progress[ch]) begin
                        txint_q[ch] <= 1'b0;
                    end
                    if (rx_done[ch]) begin
                        rxint_q[ch] <= 1'b1;
                    end else if (rx_sel && wdata_q == rx_progress[ch]) begin
                        rxint_q[ch] <= 1'b0;
                    end
                end
            end
            // R1: channel enabled while pointer set
            assign rx_dma_enable[ch] = (hdp_q[ch] != WORD_ZERO);
        end
    endgenerate
    assign tx_chan_int = txint_q;
    assign rx_chan_int = rxint_q;

    // R6: clear sequencer after reset release
    wire clr_now = (clr_st_q == CLR_WAIT) && (clr_cnt_q == STAT_CLR_LAST);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clr_st_q  <= CLR_WAIT;
            clr_cnt_q <= 6'h00;
            ready_q   <= 1'b0;
        end else begin
            unique case (clr_st_q)
                CLR_WAIT: begin
                    clr_cnt_q <= clr_cnt_q + 6'h01;
                    if (clr_now) begin
                        clr_st_q <= CLR_RUN;
                        ready_q  <= 1'b1;
                    end
                end
                CLR_RUN: begin
                    clr_cnt_q <= clr_cnt_q;
                end
                default: begin
                    clr_st_q <= CLR_WAIT;
                end
            endcase
        end
    end

    // R21: receive error during frame marks code error
    wire code_now = code_err_q || (rx_active && receive_error_input);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code_err_q     <= 1'b0;
            code_discard_q <= 1'b0;
        end else begin
            code_err_q     <= frame_end ? 1'b0 : code_now;
            code_discard_q <= frame_end && code_now;
        end
    end
    assign code_discard = code_discard_q;

    // R19: crc error
    wire crc_err   = !frame.odd_nibbles && !frame.fcs_ok;
    // R20: alignment error
    wire align_err = frame.odd_nibbles && !frame.fcs_ok_trunc;
    // R22: length window from programmed maximum
    wire len_ok    = (frame.byte_count >= MIN_FRAME) &&
                     (frame.byte_count <= maxlen_q);
    // R15: good frame; R18: overrun excluded
    wire good      = frame_end && !frame.overrun && frame.addr_match &&
                     len_ok && !crc_err && !align_err && !code_now;
    // R16: broadcast subset
    wire bcast     = good && frame.dest_bcast;
    // R17: multicast other than broadcast
    wire mcast     = good && frame.dest_mcast && !frame.dest_bcast;
    wire [NSTAT-1:0] stat_inc = {mcast, bcast, good};

    // R14: three 32-bit mapped counters
    logic [NSTAT-1:0] stat_top;
    genvar si;
    generate
        for (si = 0; si < NSTAT; si++) begin : g_stat
            mcps_stat_cmd_t cmd;
            // one driver for the whole command word
            assign cmd = {clr_now, stat_inc[si],
                          wr_stat && (w_idx == 3'(si)), gig_q, wdata_q};
            mcps_stat_counter i_mcps_stat_counter (
                .aclk    (aclk),
                .aresetn (aresetn),
                .cmd     (cmd),
                .count_q (stat_q[si])
            );
            assign stat_top[si] = stat_q[si][STAT_TOP_BIT];
        end
    endgenerate

    // R11: threshold interrupt; R12: cleared once all fall below
    assign statistics_interrupt_pending = statie_q && (|stat_top);

    // R1: pointer write enables channel
    property p_dma_en;
        @(posedge aclk) disable iff (!aresetn)
        (wr_hdp && !hdp_bad && wdata_q != WORD_ZERO && !rx_hdp_clear[w_idx])
            |=> rx_dma_enable[$past(w_idx)];
    endproperty
    a_dma_en: assert property (p_dma_en) else $error("dma not enabled"); // R1

    // R5: matching rx completion write drops interrupt
    property p_cp;
        @(posedge aclk) disable iff (!aresetn)
        (wr_rxcp && wdata_q == rx_progress[w_idx] && !rx_done[w_idx])
            |=> !rx_chan_int[$past(w_idx)];
    endproperty
    a_cp: assert property (p_cp) else $error("interrupt kept"); // R5

    // R6: counters zero right after the clear edge
    property p_clr;
        @(posedge aclk) disable iff (!aresetn)
        $rose(ready_q) |-> (stat_q[0] == WORD_ZERO) &&
            (stat_q[1] == WORD_ZERO) && (stat_q[2] == WORD_ZERO) &&
            (clr_cnt_q == STAT_CLR_CNT);
    endproperty
    a_clr: assert property (p_clr) else $error("clear timing off"); // R6

    // R18: overrun frames never counted
    property p_ovr;
        @(posedge aclk) disable iff (!aresetn)
        (frame_end && frame.overrun && !wr_stat && !clr_now)
            |=> $stable(stat_q[0]) && $stable(stat_q[1]) &&
                $stable(stat_q[2]);
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun counted"); // R18

    // R11: pending set when enabled and the good counter top bit is set
    property p_stint;
        @(posedge aclk) disable iff (!aresetn)
        (statie_q && stat_q[STAT_GOOD[1:0]] >= 32'h8000_0000)
            |-> statistics_interrupt_pending;
    endproperty
    a_stint: assert property (p_stint) else $error("no stat irq"); // R11

endmodule // mcps_regs
`default_nettype wire

// file: mcps_stat_counter.sv
`timescale 1ns/1ns
`default_nettype none
module mcps_stat_counter (
    // clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // command and count
    input  wire mcps_pkg::mcps_stat_cmd_t cmd,
    output logic [31:0]                  count_q
);
    import mcps_pkg::*;

    logic [31:0] count_d;
    logic [31:0] diff;

    // write beats a same-cycle increment; increment wraps at full scale
    assign diff = count_q - cmd.wdata;
    always_comb begin
        count_d = count_q;
        if (cmd.clear) begin
            count_d = WORD_ZERO;
        end else if (cmd.wr && cmd.dec_mode) begin
            // R7: subtract; R8: clamp at zero
            count_d = (cmd.wdata > count_q) ? WORD_ZERO : diff;
        end else if (cmd.wr) begin
            // R9: direct store
            count_d = cmd.wdata;
        end else if (cmd.inc) begin
            // R13: increment wraps
            count_d = count_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= WORD_ZERO;
        end else begin
            count_q <= count_d;
        end
    end

    // R13: wrap check
    property p_wrap;
        @(posedge aclk) disable iff (!aresetn)
        (cmd.inc && !cmd.wr && !cmd.clear && count_q == 32'hffff_ffff)
            |=> count_q == WORD_ZERO;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap"); // R13

    // R7: decrement check
    property p_dec;
        @(posedge aclk) disable iff (!aresetn)
        (cmd.wr && cmd.dec_mode && !cmd.clear && cmd.wdata <= count_q)
            |=> count_q == $past(count_q) - $past(cmd.wdata);
    endproperty
    a_dec: assert property (p_dec) else $error("bad decrement"); // R7

    // R8: saturate at zero
    property p_sat;
        @(posedge aclk) disable iff (!aresetn)
        (cmd.wr && cmd.dec_mode && cmd.wdata > count_q) |=> count_q == 32'h0;
    endproperty
    a_sat: assert property (p_sat) else $error("no saturation"); // R8

    // R9: direct write check
    property p_direct;
        @(posedge aclk) disable iff (!aresetn)
        (cmd.wr && !cmd.dec_mode && !cmd.clear)
            |=> count_q == $past(cmd.wdata);
    endproperty
    a_direct: assert property (p_direct) else $error("direct write lost"); // R9

endmodule // mcps_stat_counter
`default_nettype wire
